// ---- hdl/rsxsa_pkg.sv ----
// Package with opcodes, register map, field positions and reset values for the ALU group.
// Summary of operation
// - Rotate right via carry shifts the file register right; only carry changes.
// - Destination bit 0 writes the accumulator, 1 writes the file register (0 to 127).
// - Sleep clears the power-down flag and sets the watchdog expiry flag.
// - Sleep resets the watchdog counter and its prescaler to zero.
// - After sleep the core enters low-power state with the oscillator halted.
// - Literal minus accumulator, two's complement, into accumulator; affects C, DC, Z.
// - File minus accumulator, two's complement, to selected destination; affects C, DC, Z.
// - Carry is 1 when accumulator <= other operand; half carry likewise on bits 3:0.
// - Literal XOR accumulator into accumulator; only zero flag updates.
// - Accumulator XOR file register to selected destination; only zero flag updates.
// - Nibble swap of file register to selected destination; no flags change.
package rsxsa_pkg;

  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int OP_W = 3;
  localparam int BUS_ADDR_W = 8;

  localparam logic [OP_W-1:0] OP_NOP = 3'h0;
  localparam logic [OP_W-1:0] OP_ROTATE_RIGHT_VIA_CARRY = 3'h1;
  localparam logic [OP_W-1:0] OP_SUBTRACT_W_FROM_LITERAL = 3'h2;
  localparam logic [OP_W-1:0] OP_SUBTRACT_W_FROM_FILE = 3'h3;
  localparam logic [OP_W-1:0] OP_XOR_LITERAL_INTO_ACC = 3'h4;
  localparam logic [OP_W-1:0] OP_XOR_ACC_WITH_FILE = 3'h5;
  localparam logic [OP_W-1:0] OP_NIBBLE_SWAP_FILE = 3'h6;
  localparam logic [OP_W-1:0] OP_SLEEP = 3'h7;

  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  localparam logic [BUS_ADDR_W-1:0] ADDR_FILE_LAST = 8'h7F;
  localparam logic [BUS_ADDR_W-1:0] ADDR_ACC = 8'h80;
  localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 8'h81;
  localparam logic [BUS_ADDR_W-1:0] ADDR_WDT_COUNT = 8'h82;
  localparam logic [BUS_ADDR_W-1:0] ADDR_WDT_PRESCALE = 8'h83;
  localparam logic [BUS_ADDR_W-1:0] ADDR_CONTROL = 8'h84;

  localparam int ST_CARRY = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_WDT_EXPIRY = 4;
  localparam int CTL_WDT_ENABLE = 0;
  localparam int CTL_SLEEPING = 1;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'h0;
  localparam logic POWER_DOWN_RESET = 1'h1;
  localparam logic WDT_EXPIRY_RESET = 1'h1;
  localparam logic WDT_ENABLE_RESET = 1'h0;
  localparam int WDT_PRESCALE_W = 8;
  localparam int WDT_COUNT_W = 8;

endpackage : rsxsa_pkg

// ---- hdl/rsxsa_sync.sv ----
// Two-flop synchroniser for levels arriving from outside the clock domain.
module rsxsa_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Asynchronous level in, synchronised level out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_chk
    $error("rsxsa_sync needs WIDTH of at least one");
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : rsxsa_sync

// ---- hdl/rsxsa_sub.sv ----
// Two's complement subtractor with borrow-style carry and half carry.
module rsxsa_sub #(
  parameter int WIDTH = 8
) (
  // Operands: the result is minuend minus subtrahend.
  input wire logic [WIDTH-1:0] minuend_in,
  input wire logic [WIDTH-1:0] subtrahend_in,
  // Difference and flags.
  output logic [WIDTH-1:0] diff_out,
  output logic carry_out,
  output logic half_carry_out
);

  logic [WIDTH:0] full_sum;
  logic [4:0] low_sum;

  if (WIDTH < 5) begin : g_chk
    $error("rsxsa_sub needs WIDTH of at least five");
  end

  // Adding the complement plus one leaves carry high when no borrow occurs.
  assign full_sum = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {{WIDTH{1'b0}}, 1'b1};
  assign low_sum = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + 5'h01;
  assign diff_out = full_sum[WIDTH-1:0];
  assign carry_out = full_sum[WIDTH];
  assign half_carry_out = low_sum[4];

endmodule : rsxsa_sub

// ---- hdl/rsxsa_top.sv ----
// Execution unit for rotate, subtract, exclusive OR, nibble swap and sleep instructions.
module rsxsa_top
  import rsxsa_pkg::*;
#(
  parameter int FILE_WORDS = 128,
  parameter int PRESCALE_W = WDT_PRESCALE_W,
  parameter int COUNT_W = WDT_COUNT_W
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Instruction from the decoder.
  input wire logic instr_valid_in,
  input wire logic [OP_W-1:0] instr_op_in,
  input wire logic [FADDR_W-1:0] instr_file_in,
  input wire logic instr_dest_in,
  input wire logic [DATA_W-1:0] instr_literal_in,
  // Instruction answer.
  output logic instr_ready_out,
  output logic instr_done_out,
  // Register port.
  input wire logic [BUS_ADDR_W-1:0] bus_addr_in,
  input wire logic [DATA_W-1:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [DATA_W-1:0] bus_rdata_out,
  // Wake pin and power control.
  input wire logic wake_pin_in,
  output logic osc_run_out,
  output logic wdt_reset_out,
  // Core state.
  output logic [DATA_W-1:0] acc_out,
  output logic [DATA_W-1:0] status_out
);

  if (FILE_WORDS < 1 || FILE_WORDS > 128) begin : g_chk_file
    $error("FILE_WORDS must lie between 1 and 128");
  end
  if (PRESCALE_W < 1 || PRESCALE_W > DATA_W) begin : g_chk_pre
    $error("PRESCALE_W must lie between 1 and 8");
  end
  if (COUNT_W < 1 || COUNT_W > DATA_W) begin : g_chk_cnt
    $error("COUNT_W must lie between 1 and 8");
  end

  typedef enum logic [0:0] {
    PWR_RUN,
    PWR_SLEEP
  } rsxsa_pwr_e;

  rsxsa_pwr_e pwr_reg;
  rsxsa_pwr_e pwr_next;

  logic [DATA_W-1:0] file_mem [FILE_WORDS];
  logic [DATA_W-1:0] acc_reg;
  logic carry_reg;
  logic half_carry_reg;
  logic zero_reg;
  logic power_down_flag_reg;
  logic watchdog_expiry_flag_reg;
  logic wdt_enable_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [COUNT_W-1:0] watchdog_counter_reg;
  logic wake_sync;

  logic exec;
  logic file_hit;
  logic [DATA_W-1:0] file_data;
  logic [DATA_W-1:0] result;
  logic wr_acc;
  logic wr_file;
  logic upd_carry;
  logic upd_half;
  logic upd_zero;
  logic carry_new;
  logic half_new;
  logic is_sleep;
  logic [DATA_W-1:0] sub_minuend;
  logic [DATA_W-1:0] sub_diff;
  logic sub_carry;
  logic sub_half;
  logic prescale_wrap;
  logic wdt_overflow;
  logic bus_wr_file;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] control_word;
  logic [DATA_W-1:0] rd_mux;

  rsxsa_sync #(
    .WIDTH(1)
  ) u_wake_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(wake_pin_in),
    .sync_out(wake_sync)
  );

  // Instructions are taken only while the core runs.
  assign exec = instr_valid_in && (pwr_reg == PWR_RUN);
  assign file_hit = 32'(instr_file_in) < FILE_WORDS;
  assign file_data = file_hit ? file_mem[instr_file_in] : 8'h00;

  // Subtraction takes the literal or the file register as minuend.
  assign sub_minuend = (instr_op_in == OP_SUBTRACT_W_FROM_LITERAL) ? instr_literal_in : file_data;

  rsxsa_sub #(
    .WIDTH(DATA_W)
  ) u_sub (
    .minuend_in(sub_minuend),
    .subtrahend_in(acc_reg),
    .diff_out(sub_diff),
    .carry_out(sub_carry),
    .half_carry_out(sub_half)
  );

  // Instruction decode into result, destination and flag updates.
  always_comb begin
    result = acc_reg;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_carry = 1'b0;
    upd_half = 1'b0;
    upd_zero = 1'b0;
    carry_new = carry_reg;
    half_new = half_carry_reg;
    is_sleep = 1'b0;
    unique case (instr_op_in)
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        result = {carry_reg, file_data[DATA_W-1:1]};
        carry_new = file_data[0];
        upd_carry = 1'b1;
        wr_acc = (instr_dest_in == DEST_ACC);
        wr_file = (instr_dest_in == DEST_FILE);
      end
      OP_SUBTRACT_W_FROM_LITERAL: begin
        result = sub_diff;
        carry_new = sub_carry;
        half_new = sub_half;
        upd_carry = 1'b1;
        upd_half = 1'b1;
        upd_zero = 1'b1;
        wr_acc = 1'b1;
      end
      OP_SUBTRACT_W_FROM_FILE: begin
        result = sub_diff;
        carry_new = sub_carry;
        half_new = sub_half;
        upd_carry = 1'b1;
        upd_half = 1'b1;
        upd_zero = 1'b1;
        wr_acc = (instr_dest_in == DEST_ACC);
        wr_file = (instr_dest_in == DEST_FILE);
      end
      OP_XOR_LITERAL_INTO_ACC: begin
        result = acc_reg ^ instr_literal_in;
        upd_zero = 1'b1;
        wr_acc = 1'b1;
      end
      OP_XOR_ACC_WITH_FILE: begin
        result = acc_reg ^ file_data;
        upd_zero = 1'b1;
        wr_acc = (instr_dest_in == DEST_ACC);
        wr_file = (instr_dest_in == DEST_FILE);
      end
      OP_NIBBLE_SWAP_FILE: begin
        result = {file_data[3:0], file_data[7:4]};
        wr_acc = (instr_dest_in == DEST_ACC);
        wr_file = (instr_dest_in == DEST_FILE);
      end
      OP_SLEEP: begin
        is_sleep = 1'b1;
      end
      default: begin
        result = acc_reg;
      end
    endcase
  end

  // File register array: an executed instruction wins over a bus write.
  assign bus_wr_file = bus_wr_in && (bus_addr_in <= ADDR_FILE_LAST)
    && (32'(bus_addr_in) < FILE_WORDS);

  always_ff @(posedge ref_clk_in) begin
    if (exec && wr_file && file_hit) begin
      file_mem[instr_file_in] <= result;
    end else if (bus_wr_file) begin
      file_mem[bus_addr_in[FADDR_W-1:0]] <= bus_wdata_in;
    end
  end

  // Accumulator.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_reg <= ACC_RESET;
    end else if (exec && wr_acc) begin
      acc_reg <= result;
    end else if (bus_wr_in && bus_addr_in == ADDR_ACC) begin
      acc_reg <= bus_wdata_in;
    end
  end

  // Arithmetic flags: instruction updates win over a bus write.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      carry_reg <= FLAG_RESET;
      half_carry_reg <= FLAG_RESET;
      zero_reg <= FLAG_RESET;
    end else begin
      if (exec && upd_carry) begin
        carry_reg <= carry_new;
      end else if (bus_wr_in && bus_addr_in == ADDR_STATUS) begin
        carry_reg <= bus_wdata_in[ST_CARRY];
      end
      if (exec && upd_half) begin
        half_carry_reg <= half_new;
      end else if (bus_wr_in && bus_addr_in == ADDR_STATUS) begin
        half_carry_reg <= bus_wdata_in[ST_HALF_CARRY];
      end
      if (exec && upd_zero) begin
        zero_reg <= (result == 8'h00);
      end else if (bus_wr_in && bus_addr_in == ADDR_STATUS) begin
        zero_reg <= bus_wdata_in[ST_ZERO];
      end
    end
  end

  // Power flags change only by hardware events.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      power_down_flag_reg <= POWER_DOWN_RESET;
      watchdog_expiry_flag_reg <= WDT_EXPIRY_RESET;
    end else if (exec && is_sleep) begin
      power_down_flag_reg <= 1'b0;
      watchdog_expiry_flag_reg <= 1'b1;
    end else if (wdt_overflow) begin
      watchdog_expiry_flag_reg <= 1'b0;
    end
  end

  // Control register.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wdt_enable_reg <= WDT_ENABLE_RESET;
    end else if (bus_wr_in && bus_addr_in == ADDR_CONTROL) begin
      wdt_enable_reg <= bus_wdata_in[CTL_WDT_ENABLE];
    end
  end

  // Watchdog prescaler and counter.
  assign prescale_wrap = wdt_enable_reg && (prescale_reg == {PRESCALE_W{1'b1}});
  assign wdt_overflow = prescale_wrap && (watchdog_counter_reg == {COUNT_W{1'b1}})
    && !(exec && is_sleep);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prescale_reg <= '0;
      watchdog_counter_reg <= '0;
    end else if (exec && is_sleep) begin
      prescale_reg <= '0;
      watchdog_counter_reg <= '0;
    end else if (wdt_enable_reg) begin
      prescale_reg <= prescale_reg + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      if (prescale_wrap) begin
        watchdog_counter_reg <= watchdog_counter_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Power state: sleep halts the oscillator until a wake pin or watchdog overflow.
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_RUN: begin
        if (exec && is_sleep) begin
          pwr_next = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wake_sync || wdt_overflow) begin
          pwr_next = PWR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pwr_reg <= PWR_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // Register port read data, valid only in the cycle after the strobe.
  assign status_word = {3'h0, watchdog_expiry_flag_reg, power_down_flag_reg,
    zero_reg, half_carry_reg, carry_reg};
  assign control_word = {6'h00, (pwr_reg == PWR_SLEEP), wdt_enable_reg};

  always_comb begin
    rd_mux = 8'h00;
    if (bus_addr_in <= ADDR_FILE_LAST) begin
      if (32'(bus_addr_in) < FILE_WORDS) begin
        rd_mux = file_mem[bus_addr_in[FADDR_W-1:0]];
      end
    end else begin
      unique case (bus_addr_in)
        ADDR_ACC: rd_mux = acc_reg;
        ADDR_STATUS: rd_mux = status_word;
        ADDR_WDT_COUNT: rd_mux = DATA_W'(watchdog_counter_reg);
        ADDR_WDT_PRESCALE: rd_mux = DATA_W'(prescale_reg);
        ADDR_CONTROL: rd_mux = control_word;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus_rdata_out <= 8'h00;
    end else if (bus_rd_in) begin
      bus_rdata_out <= rd_mux;
    end else begin
      bus_rdata_out <= 8'h00;
    end
  end

  // Instruction handshake outputs.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      instr_done_out <= 1'b0;
      instr_ready_out <= 1'b0;
    end else begin
      instr_done_out <= exec;
      instr_ready_out <= (pwr_next == PWR_RUN);
    end
  end

  // Oscillator run and watchdog reset request.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      osc_run_out <= 1'b1;
      wdt_reset_out <= 1'b0;
    end else begin
      osc_run_out <= (pwr_next == PWR_RUN);
      wdt_reset_out <= wdt_overflow && (pwr_reg == PWR_RUN);
    end
  end

  // Mirrors of core state.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_out <= ACC_RESET;
      status_out <= {3'h0, WDT_EXPIRY_RESET, POWER_DOWN_RESET, 3'h0};
    end else begin
      acc_out <= acc_reg;
      status_out <= status_word;
    end
  end

endmodule : rsxsa_top

// ---- bench/rsxsa_chk.sv ----
// Checker of the ALU group behaviour seen at the top module ports.
module rsxsa_chk
  import rsxsa_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Instruction port.
  input wire logic instr_valid_in,
  input wire logic [OP_W-1:0] instr_op_in,
  input wire logic instr_dest_in,
  input wire logic [DATA_W-1:0] instr_literal_in,
  input wire logic instr_ready_out,
  input wire logic instr_done_out,
  // Core state.
  input wire logic osc_run_out,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic [DATA_W-1:0] status_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_take(logic [OP_W-1:0] o);
    instr_valid_in && instr_ready_out && instr_op_in == o;
  endsequence
  sequence s_take_acc(logic [OP_W-1:0] o);
    s_take(o) ##0 instr_dest_in == DEST_ACC;
  endsequence
  a_done_follows: assert property (instr_valid_in && instr_ready_out |=> instr_done_out)
    else $error("done pulse missing");
  a_rot_carry_in: assert property (s_take_acc(OP_ROTATE_RIGHT_VIA_CARRY) |-> ##2
    acc_out[7] == $past(status_out[ST_CARRY]) && status_out[2:1] == $past(status_out[2:1]))
    else $error("rotate carry wrong");
  a_sleep_flags: assert property (s_take(OP_SLEEP) |-> ##2
    !status_out[ST_POWER_DOWN] && status_out[ST_WDT_EXPIRY]) else $error("sleep flags wrong");
  a_sleep_halt: assert property (s_take(OP_SLEEP) |=> !osc_run_out && !instr_ready_out)
    else $error("sleep did not halt");
  a_sub_lit_value: assert property (s_take(OP_SUBTRACT_W_FROM_LITERAL) |-> ##2
    acc_out == $past(instr_literal_in, 2) - $past(acc_out) && status_out[ST_ZERO] == (acc_out == 8'h00)
    && status_out[ST_CARRY] == ($past(acc_out) <= $past(instr_literal_in, 2))) else $error("sub literal wrong");
  a_sub_half_carry: assert property (s_take(OP_SUBTRACT_W_FROM_LITERAL) |-> ##2
    status_out[ST_HALF_CARRY] == ($past(acc_out[3:0]) <= $past(instr_literal_in[3:0], 2)))
    else $error("half carry wrong");
  a_xor_lit_value: assert property (s_take(OP_XOR_LITERAL_INTO_ACC) |-> ##2
    acc_out == ($past(instr_literal_in, 2) ^ $past(acc_out)) && status_out[ST_ZERO] == (acc_out == 8'h00)
    && status_out[1:0] == $past(status_out[1:0])) else $error("xor literal wrong");
  a_xor_file_zero: assert property (s_take_acc(OP_XOR_ACC_WITH_FILE) |-> ##2
    status_out[ST_ZERO] == (acc_out == 8'h00) && status_out[1:0] == $past(status_out[1:0]))
    else $error("xor file flags wrong");
  a_swap_flags_kept: assert property (s_take(OP_NIBBLE_SWAP_FILE) |-> ##2
    status_out[2:0] == $past(status_out[2:0])) else $error("swap changed flags");
endmodule : rsxsa_chk

bind rsxsa_top rsxsa_chk chk_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
  .instr_op_in(instr_op_in), .instr_dest_in(instr_dest_in), .instr_literal_in(instr_literal_in),
  .instr_ready_out(instr_ready_out), .instr_done_out(instr_done_out), .osc_run_out(osc_run_out),
  .acc_out(acc_out), .status_out(status_out));

// ---- bench/rsxsa_dec_model.sv ----
// Decoder model that issues one instruction per request from the bench.
module rsxsa_dec_model
  import rsxsa_pkg::*;
(
  // Clock and request.
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic [OP_W-1:0] op_in,
  input wire logic [FADDR_W-1:0] file_in,
  input wire logic dest_in,
  input wire logic [DATA_W-1:0] lit_in,
  // Instruction lines.
  output logic valid_out = 1'h0,
  output logic [OP_W-1:0] op_out = 3'h0,
  output logic [FADDR_W-1:0] file_out = 7'h00,
  output logic dest_out = 1'h0,
  output logic [DATA_W-1:0] lit_out = 8'h00
);
  // Idle operands flip every cycle so that stale values are never trusted.
  always @(posedge ref_clk_in) begin
    valid_out <= go_in;
    if (go_in) begin
      op_out <= op_in;
      file_out <= file_in;
      dest_out <= dest_in;
      lit_out <= lit_in;
    end else begin
      op_out <= ~op_out;
      file_out <= ~file_out;
      dest_out <= ~dest_out;
      lit_out <= ~lit_out;
    end
  end
endmodule : rsxsa_dec_model

// ---- bench/tb_top.sv ----
// Self-checking testbench of the ALU group.
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top
  import rsxsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic go = 1'h0;
  logic [2:0] r_op = 3'h0;
  logic [6:0] r_file = 7'h00;
  logic r_dest = 1'h0;
  logic [7:0] r_lit = 8'h00;
  logic [7:0] baddr = 8'h00;
  logic [7:0] bwdata = 8'h00;
  logic bwr = 1'h0;
  logic brd = 1'h0;
  logic wake = 1'h0;
  logic iv, idest, ready, done, osc, wdt_rst;
  logic [2:0] iop;
  logic [6:0] ifile;
  logic [7:0] ilit, rdata, acc, st, w;
  logic [7:0] mem [128];
  logic [2:0] fl;
  int n_errors = 0;
  int n_tests = 0;
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  rsxsa_dec_model dec (.ref_clk_in(ref_clk_in), .go_in(go), .op_in(r_op), .file_in(r_file), .dest_in(r_dest),
    .lit_in(r_lit), .valid_out(iv), .op_out(iop), .file_out(ifile), .dest_out(idest), .lit_out(ilit));
  rsxsa_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .instr_valid_in(iv), .instr_op_in(iop),
    .instr_file_in(ifile), .instr_dest_in(idest), .instr_literal_in(ilit), .instr_ready_out(ready),
    .instr_done_out(done), .bus_addr_in(baddr), .bus_wdata_in(bwdata), .bus_wr_in(bwr), .bus_rd_in(brd),
    .bus_rdata_out(rdata), .wake_pin_in(wake), .osc_run_out(osc), .wdt_reset_out(wdt_rst), .acc_out(acc),
    .status_out(st));
  task automatic finish_test();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    baddr <= a;
    bwdata <= d;
    bwr <= 1'h1;
    @(posedge ref_clk_in);
    bwr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    baddr <= a;
    brd <= 1'h1;
    @(posedge ref_clk_in);
    brd <= 1'h0;
    #1;
    `CHK(rdata, e)
  endtask : rd
  function automatic logic [10:0] alu(input logic [2:0] o, input logic [7:0] x, y, k, input logic [2:0] s);
    logic [7:0] a;
    logic [7:0] r;
    logic [2:0] n;
    a = (o == OP_SUBTRACT_W_FROM_LITERAL || o == OP_XOR_LITERAL_INTO_ACC) ? k : x;
    r = x;
    n = s;
    case (o)
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        r = {s[0], x[7:1]};
        n[0] = x[0];
      end
      OP_SUBTRACT_W_FROM_LITERAL, OP_SUBTRACT_W_FROM_FILE: begin
        r = a - y;
        n = {r == 8'h00, y[3:0] <= a[3:0], y <= a};
      end
      OP_XOR_LITERAL_INTO_ACC, OP_XOR_ACC_WITH_FILE: begin
        r = a ^ y;
        n[2] = r == 8'h00;
      end
      OP_NIBBLE_SWAP_FILE: r = {x[3:0], x[7:4]};
      default: n = s;
    endcase
    return {r, n};
  endfunction : alu
  task automatic exec(input logic [2:0] o, input logic [6:0] f, input logic d, input logic [7:0] l, input logic live);
    logic [10:0] e;
    logic uf;
    e = alu(o, mem[f], w, l, fl);
    uf = o inside {OP_ROTATE_RIGHT_VIA_CARRY, OP_SUBTRACT_W_FROM_FILE, OP_XOR_ACC_WITH_FILE, OP_NIBBLE_SWAP_FILE};
    @(posedge ref_clk_in);
    go <= 1'h1;
    r_op <= o;
    r_file <= f;
    r_dest <= d;
    r_lit <= l;
    @(posedge ref_clk_in);
    go <= 1'h0;
    @(posedge ref_clk_in);
    #1;
    `CHK(done, live)
    if (live) begin
      fl = e[2:0];
      if (uf && d) mem[f] = e[10:3];
      else if (o != OP_SLEEP && o != OP_NOP) w = e[10:3];
    end
    @(posedge ref_clk_in);
    #1;
    `CHK(acc, w)
    `CHK(st[2:0], fl)
    if (uf) rd({1'h0, f}, mem[f]);
  endtask : exec
  initial begin
    logic [7:0] v;
    logic [2:0] o;
    int i;
    v = 8'($urandom(60));
    w = 8'h00;
    fl = 3'h0;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    #1;
    `CHK(acc, ACC_RESET)
    `CHK(st, {3'h0, WDT_EXPIRY_RESET, POWER_DOWN_RESET, 3'h0})
    for (i = 0; i < 128; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      mem[i] = v;
      wr(8'(i), v);
    end
    rd(8'h7F, mem[127]);
    rd(8'h90, 8'h00);
    exec(OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'h0, w, 1'h1);
    exec(OP_SUBTRACT_W_FROM_LITERAL, 7'h00, 1'h0, 8'h00, 1'h1);
    exec(OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'h0, 8'h0F, 1'h1);
    exec(OP_SUBTRACT_W_FROM_LITERAL, 7'h00, 1'h0, 8'h10, 1'h1);
    exec(OP_SUBTRACT_W_FROM_FILE, 7'h00, 1'h1, 8'h00, 1'h1);
    exec(OP_ROTATE_RIGHT_VIA_CARRY, 7'h00, 1'h0, 8'h00, 1'h1);
    exec(OP_ROTATE_RIGHT_VIA_CARRY, 7'h00, 1'h1, 8'h00, 1'h1);
    exec(OP_NIBBLE_SWAP_FILE, 7'h7F, 1'h1, 8'h00, 1'h1);
    exec(OP_XOR_ACC_WITH_FILE, 7'h7F, 1'h1, 8'h00, 1'h1);
    wr(ADDR_CONTROL, 8'h01);
    exec(OP_SLEEP, 7'h00, 1'h0, 8'h00, 1'h1);
    `CHK({osc, ready}, 2'h0)
    `CHK(st[4:3], 2'h2)
    rd(ADDR_WDT_PRESCALE, 8'h02);
    rd(ADDR_WDT_COUNT, 8'h00);
    exec(OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'h0, 8'hFF, 1'h0);
    @(posedge ref_clk_in);
    wake <= 1'h1;
    i = 0;
    while (osc !== 1'h1) begin
      if (i++ == 10) begin
        n_errors++;
        finish_test();
      end
      @(posedge ref_clk_in);
      #1;
    end
    `CHK(ready, 1'h1)
    @(posedge ref_clk_in);
    wake <= 1'h0;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_ACC, 8'h5A);
    wr(ADDR_STATUS, 8'h07);
    w = 8'h5A;
    fl = 3'h7;
    rd(ADDR_ACC, 8'h5A);
    rd(ADDR_STATUS, 8'h17);
    rd(ADDR_CONTROL, 8'h00);
    exec(OP_NOP, 7'h00, 1'h0, 8'h00, 1'h1);
    for (i = 0; i < 300; i++) begin
      o = 3'($urandom_range(6, 1));
      v = 8'($urandom);
      exec(o, 7'($urandom), 1'($urandom), v, 1'h1);
    end
    wr(ADDR_CONTROL, 8'h01);
    i = 0;
    while (wdt_rst !== 1'h1) begin
      if (i++ == 70000) begin
        n_errors++;
        finish_test();
      end
      @(posedge ref_clk_in);
      #1;
    end
    `CHK(ready, 1'h1)
    @(posedge ref_clk_in);
    #1;
    `CHK({wdt_rst, st[4]}, 2'h0)
    finish_test();
  end
endmodule : tb_top
